//--- verilog/pst_pkg.sv
/*
 * Package for the prescaled 16-bit timer: register map, field positions,
 * reset values and prescale figures.
 * Assumes a 32-bit classic Wishbone bus with byte addressing.
 */
package pst_pkg;
	localparam logic [7:0] PST_ADDR_CTRL = 8'h00;
	localparam logic [7:0] PST_ADDR_COUNT = 8'h04;
	localparam logic [7:0] PST_ADDR_PERIOD = 8'h08;
	localparam logic [7:0] PST_ADDR_STATUS = 8'h0C;
	localparam logic [7:0] PST_ADDR_MASK = 8'h10;
	localparam int PST_BIT_RUN = 15;
	localparam int PST_BIT_IDLE_HALT = 13;
	localparam int PST_BIT_GATE = 6;
	localparam int PST_BIT_PS_HI = 5;
	localparam int PST_BIT_PS_LO = 4;
	localparam int PST_BIT_SYNC = 2;
	localparam int PST_BIT_SRC = 1;
	localparam logic [15:0] PST_CTRL_WMASK = 16'hA076;
	localparam logic [15:0] PST_CTRL_RESET = 16'h0000;
	localparam logic [15:0] PST_COUNT_RESET = 16'h0000;
	localparam logic [15:0] PST_PERIOD_RESET = 16'hFFFF;
	localparam int PST_EV_PERIOD = 0;
	localparam int PST_EV_GATE = 1;
	localparam int PST_NUM_EV = 2;
	localparam logic [7:0] PST_DIV_1 = 8'h00;
	localparam logic [7:0] PST_DIV_8 = 8'h07;
	localparam logic [7:0] PST_DIV_64 = 8'h3F;
	localparam logic [7:0] PST_DIV_256 = 8'hFF;
	typedef enum logic [1:0] {
		PST_MODE_TIMER,
		PST_MODE_GATED,
		PST_MODE_SYNC_CNT,
		PST_MODE_ASYNC_CNT
	} pst_mode_t;
endpackage

//--- verilog/pst_prescaler.sv
/*
 * Prescaler: counts input ticks and emits one output tick per 1, 8, 64
 * or 256 input ticks. Each clk_i cycle with tick_i high counts as one input tick.
 */
`timescale 1ns/1ns
module pst_prescaler
	import pst_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic [1:0] select_i,
	output logic tick_o
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic [7:0] limit;
	logic wrap;

	assign limit = (select_i == 2'h3) ? PST_DIV_256 :
		(select_i == 2'h2) ? PST_DIV_64 :
		(select_i == 2'h1) ? PST_DIV_8 : PST_DIV_1;
	assign wrap = tick_i && (cnt_ff >= limit);
	assign nxt_cnt = clear_i ? 8'h00 : wrap ? 8'h00 : tick_i ? cnt_ff + 8'h01 : cnt_ff;
	assign tick_o = wrap && !clear_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule

//--- verilog/pst_timer.sv
/*
 * Prescaled 16-bit timer/counter with control, count, period, status and
 * mask registers on classic Wishbone; one level interrupt output.
 * Assumes ext_count_i, gate_i and idle_i are synchronous to clk_i.
 */
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ns
module pst_timer
	import pst_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_count_i,
	input wire logic gate_i,
	input wire logic idle_i,
	output logic irq_o,
	output logic [1:0] mode_o
);
	logic [15:0] ctrl_ff;
	logic [15:0] count_ff;
	logic [15:0] period_ff;
	logic [PST_NUM_EV-1:0] status_ff;
	logic [PST_NUM_EV-1:0] mask_ff;
	logic ext_prev_ff;
	logic gate_prev_ff;
	logic ps_sync_ff;
	logic [31:0] rdata;
	logic req;
	logic wr;
	logic rd;
	logic lo_en;
	logic hi_en;
	logic run;
	logic src_ext;
	logic sync_en;
	logic gate_en;
	logic halted;
	logic ext_rise;
	logic gate_fall;
	logic raw_tick;
	logic ps_tick;
	logic cnt_tick;
	logic period_hit;
	logic count_wr;
	logic [15:0] ctrl_wdata;
	logic [15:0] nxt_ctrl;
	logic [15:0] nxt_count;
	logic [15:0] nxt_period;
	logic [PST_NUM_EV-1:0] events;
	logic [PST_NUM_EV-1:0] nxt_status;
	logic [PST_NUM_EV-1:0] nxt_mask;
	pst_mode_t mode;

	// bus decode: single-cycle ack, never two acks in a row
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i;
	assign rd = req && !wb_we_i;
	assign lo_en = wb_sel_i[0];
	assign hi_en = wb_sel_i[1];

	assign run = ctrl_ff[PST_BIT_RUN];
	assign src_ext = ctrl_ff[PST_BIT_SRC];
	assign sync_en = src_ext && ctrl_ff[PST_BIT_SYNC];
	assign gate_en = !src_ext && ctrl_ff[PST_BIT_GATE];
	assign halted = ctrl_ff[PST_BIT_IDLE_HALT] && idle_i;

	always_comb begin
		case ({src_ext, src_ext ? ctrl_ff[PST_BIT_SYNC] : ctrl_ff[PST_BIT_GATE]})
			2'b00: mode = PST_MODE_TIMER;
			2'b01: mode = PST_MODE_GATED;
			2'b11: mode = PST_MODE_SYNC_CNT;
			2'b10: mode = PST_MODE_ASYNC_CNT;
			default: mode = PST_MODE_TIMER;
		endcase
	end

	// external pin counts on rising edges only
	assign ext_rise = ext_count_i && !ext_prev_ff;
	assign gate_fall = gate_prev_ff && !gate_i;
	// gated mode accumulates only while the gate is high
	assign raw_tick = run && !halted && (src_ext ? ext_rise : (!gate_en || gate_i));

	pst_prescaler u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(!run),
		.tick_i(raw_tick),
		.select_i(ctrl_ff[PST_BIT_PS_HI:PST_BIT_PS_LO]),
		.tick_o(ps_tick)
	);

	// sync stage sits after the prescaler; costs one cycle of latency
	assign cnt_tick = sync_en ? ps_sync_ff : ps_tick;
	assign period_hit = cnt_tick && (count_ff == period_ff);

	assign ctrl_wdata = {hi_en ? wb_dat_i[15:8] : ctrl_ff[15:8], lo_en ? wb_dat_i[7:0] : ctrl_ff[7:0]};
	assign nxt_ctrl = (wr && wb_adr_i == PST_ADDR_CTRL) ? (ctrl_wdata & PST_CTRL_WMASK) : ctrl_ff;

	// writes refused while a running synchronous counter owns the count
	assign count_wr = wr && (wb_adr_i == PST_ADDR_COUNT) && !(src_ext && ctrl_ff[PST_BIT_SYNC] && run);
	assign nxt_count = count_wr ?
		{hi_en ? wb_dat_i[15:8] : count_ff[15:8], lo_en ? wb_dat_i[7:0] : count_ff[7:0]} :
		period_hit ? 16'h0000 :
		cnt_tick ? count_ff + 16'h0001 : count_ff;

	assign nxt_period = (wr && wb_adr_i == PST_ADDR_PERIOD) ?
		{hi_en ? wb_dat_i[15:8] : period_ff[15:8], lo_en ? wb_dat_i[7:0] : period_ff[7:0]} : period_ff;

	assign events[PST_EV_PERIOD] = period_hit;
	assign events[PST_EV_GATE] = gate_en && run && !halted && gate_fall;
	// a new event wins over the clear-on-read
	assign nxt_status = ((rd && wb_adr_i == PST_ADDR_STATUS) ? {PST_NUM_EV{1'b0}} : status_ff) | events;
	assign nxt_mask = (wr && wb_adr_i == PST_ADDR_MASK && lo_en) ? wb_dat_i[PST_NUM_EV-1:0] : mask_ff;

	always_comb begin
		case (wb_adr_i)
			PST_ADDR_CTRL: rdata = {16'h0000, ctrl_ff};
			PST_ADDR_COUNT: rdata = {16'h0000, count_ff};
			PST_ADDR_PERIOD: rdata = {16'h0000, period_ff};
			PST_ADDR_STATUS: rdata = {{(32 - PST_NUM_EV){1'b0}}, status_ff};
			PST_ADDR_MASK: rdata = {{(32 - PST_NUM_EV){1'b0}}, mask_ff};
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff <= PST_CTRL_RESET;
			count_ff <= PST_COUNT_RESET;
			period_ff <= PST_PERIOD_RESET;
			status_ff <= {PST_NUM_EV{1'b0}};
			mask_ff <= {PST_NUM_EV{1'b0}};
			ext_prev_ff <= 1'b0;
			gate_prev_ff <= 1'b0;
			ps_sync_ff <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			irq_o <= 1'b0;
			mode_o <= 2'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			count_ff <= nxt_count;
			period_ff <= nxt_period;
			status_ff <= nxt_status;
			mask_ff <= nxt_mask;
			ext_prev_ff <= ext_count_i;
			gate_prev_ff <= gate_i;
			ps_sync_ff <= ps_tick && sync_en;
			wb_ack_o <= req;
			wb_dat_o <= rd ? rdata : 32'h0000_0000;
			irq_o <= |(nxt_status & nxt_mask);
			mode_o <= mode;
		end
	end
endmodule

//--- bench/pst_timer_assertions.sv
/* port checker bound to pst_timer; assumes a registered one-cycle bus answer */
`timescale 1ns/1ns
module pst_chk
	import pst_pkg::*;
(
	input logic clk_i,
	input logic rst_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	input logic irq_o,
	input logic [1:0] mode_o
);
wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire rd = tk & ~wb_we_i;
wire wc = tk & wb_we_i & wb_sel_i[0] & (wb_adr_i == PST_ADDR_CTRL);
// no reset needed: only looked at two cycles after a write
logic [6:0] c_ff;
always_ff @(posedge clk_i) if (wc) c_ff <= wb_dat_i[6:0];
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
chk_ack_take: assert property (tk |=> wb_ack_o) else $error("no ack");
chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper bits set");
chk_unmapped_zero: assert property ($past(rd && wb_adr_i > PST_ADDR_MASK) |-> wb_dat_o == 32'h0) else $error("unmapped");
chk_ctrl_unused: assert property ($past(rd && wb_adr_i == PST_ADDR_CTRL) |-> (wb_dat_o & 32'h5F89) == 32'h0)
	else $error("unused bit set");
chk_mode_decode: assert property (wc |-> ##2 mode_o == {c_ff[1], c_ff[1] ? !c_ff[2] : c_ff[6]})
	else $error("bad mode");
chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !wb_ack_o && mode_o == 2'h0) else $error("reset");
endmodule
bind pst_timer pst_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .irq_o(irq_o), .mode_o(mode_o));

//--- bench/tb_pst_timer.sv
/* self-checking bench for pst_timer; assumes package, design and checker compiled first */
`timescale 1ns/1ns
module tb_pst_timer;
logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ext = 0, gate = 0, ack, irq;
logic [7:0] adr = 8'h00;
logic [31:0] wd = 32'h0, dat, rd;
int err_count = 0, compares = 0, k, n, dv[4] = '{1, 8, 64, 256};
always #5 clk_i = ~clk_i;
pst_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
	.wb_sel_i(4'h3), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .ext_count_i(ext), .gate_i(gate),
	.idle_i(1'b0), .irq_o(irq), .mode_o());
task automatic summarize();
	$display("compares %0d err_count %0d", compares, err_count);
	if (err_count == 0 && compares > 0) $display("Finished cleanly");
	else $display("Finished with errors");
	$finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	compares++;
	err_count += int'(got !== exp);
	if (got !== exp) $display("unexpected at %0t: %h not %h", $time, got, exp);
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	{cyc, we, adr, wd} <= {1'b1, w, a, d};
	do @(posedge clk_i); while (ack !== 1'b1);
	rd = dat;
	cyc <= 1'b0;
	@(posedge clk_i);
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] e);
	bus(1'b0, a, 32'h0);
	chk(rd, e);
endtask
task automatic pulse(input int m);
	repeat (2 * m) @(posedge clk_i) ext <= ~ext;
	repeat (3) @(posedge clk_i); // slack for the edge detector and count register
endtask
task automatic setup(input logic [31:0] c);
	bus(1'b1, 8'h00, 32'h0);
	bus(1'b1, 8'h04, 32'h0);
	bus(1'b1, 8'h00, c);
endtask
initial begin
	repeat (20000) @(posedge clk_i);
	err_count++;
	summarize();
end
initial begin
	void'($urandom(25));
	repeat (3) @(posedge clk_i);
	rst_i <= 1'b0;
	rdc(8'h40, 32'h0);
	bus(1'b1, 8'h00, 32'hFFFFFFFF);
	rdc(8'h00, 32'hA076);
	for (n = 1; n < 4; n++) begin
		k = $urandom % 4 + 1;
		setup(32'h8000 | n << 4 | $urandom % 2 << 2);
		repeat (dv[n] * k + dv[n] / 2 - 3) @(posedge clk_i);
		bus(1'b1, 8'h00, 32'h0);
		rdc(8'h04, k);
	end
	n = $urandom % 20 + 1;
	setup(32'h8042);
	pulse(n);
	rdc(8'h04, n);
	setup(32'h8016);
	pulse(8 * n);
	rdc(8'h04, n);
	bus(1'b1, 8'h04, 32'h55);
	rdc(8'h04, n);
	setup(32'h8002);
	bus(1'b1, 8'h08, 32'h3);
	pulse(6);
	rdc(8'h04, 32'h2);
	chk(irq, 1'b0);
	bus(1'b1, 8'h10, 32'h1);
	chk(irq, 1'b1);
	rdc(8'h0C, 32'h1);
	chk(irq, 1'b0);
	bus(1'b1, 8'h08, 32'hFFFF);
	setup(32'h8040);
	repeat (20) @(posedge clk_i);
	rdc(8'h04, 32'h0);
	gate <= 1'b1;
	repeat (9) @(posedge clk_i);
	gate <= 1'b0;
	repeat (3) @(posedge clk_i);
	rdc(8'h0C, 32'h2);
	summarize();
end
endmodule
